// [deep_fifo_x36.sv]
// deep dual-clock fifo, 36 bits wide, with offsets, mark and retransmit
// assumes clock is the write clock, read_clock the consumer clock; pins are asynchronous
// Notes on behaviour
// RULE_01: storage of 524288 words of 36 bits, strictly first in first out
// RULE_02: synchronous write takes data each write clock edge with write enable low
// RULE_03: asynchronous write takes data on each rising write strobe edge
// RULE_04: write chip select high blocks all data from the write side; parallel offset loads here ignore it
// RULE_05: synchronous read moves next word out each read edge with enable low
// RULE_06: asynchronous read moves a word on each rising read strobe edge
// RULE_07: asynchronous reads need standard timing, chip select low, output enable
// RULE_08: outputs float when output enable high or sampled chip select high
// RULE_09: write and read clocks are independent, up to 200 MHz each
// RULE_10: standard timing shows a word only after a real read
// RULE_11: fall-through shows the first word without a read; later words need reads
// RULE_12: empty and full, or output-ready and input-ready, plus almost flags
// RULE_13: each flag comes as a pair, combined outside by gating
// RULE_14: master reset picks one of eight default offsets from three pins
// RULE_15: serial clock shifts one offset bit while enable and load are low
// RULE_16: write clock loads offsets from input bus while enable and load low
// RULE_17: read with load low returns the offsets on the output bus
// RULE_18: master reset clears both pointers and latches the timing mode
// RULE_19: partial reset clears pointers, keeps mode, method and offsets
// RULE_20: asynchronous almost flags: set on one clock, released on the other; the code ANDs both halves, so a flag releases on the clock that set it
// RULE_21: synchronous almost flags change only on their own clock
// RULE_22: mark records the read location; retransmit low returns there
// RULE_23: read-port select at master reset picks clocked or strobed reads
// RULE_24: write-port select at master reset picks clocked or strobed writes
// RULE_25: load pin at master reset picks serial or parallel offset loading
// RULE_26: writes when full and reads when empty are ignored
// RULE_27: pointers cross clock domains in gray code
module deep_fifo_x36
    import fifo_x36_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic read_clock,
    input wire logic [`DATA_BITS-1:0] input_data_bus,
    input wire logic write_enable_n,
    input wire logic write_strobe,
    input wire logic write_chip_select_n,
    input wire logic read_enable_n,
    input wire logic read_strobe,
    input wire logic read_chip_select_n,
    input wire logic output_enable_n,
    output word_type output_data_bus,
    output logic output_data_enable,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic mode_or_serial_input,
    input wire logic default_offset_select_0,
    input wire logic default_offset_select_1,
    input wire logic offset_load_n,
    input wire logic serial_clock,
    input wire logic serial_load_enable_n,
    input wire logic almost_flag_timing_select,
    input wire logic read_port_async_select,
    input wire logic write_port_async_select,
    input wire logic replay_mark,
    input wire logic retransmit_n,
    output logic [1:0] empty_flag_n,
    output logic [1:0] full_flag_n,
    output logic [1:0] almost_empty_flag_n,
    output logic [1:0] almost_full_flag_n
);
    // ---- write domain signals
    logic [10:0] wpin;
    logic mres_s, pres_s, ser_s, wstb_s, sclk_s, sle_s, dsel1_s, dsel0_s;
    logic rmode_s, wmode_s, afm_s;
    logic wstb_d, sclk_d;
    logic wr_reset, fall_through_mode, wr_async, rd_async, flag_async, parallel_load;
    logic reset_level, par_sel;
    offset_type empty_offset, full_offset;
    ptr_type wr_ptr, wr_gray, rd_gray_w, rd_ptr_w, wr_count;
    logic wr_request, wr_fire, full, wr_full_n, wr_ae_n, wr_af_n;

    // ---- read domain signals
    logic [6:0] rpin;
    logic rstb_s, rwd_s, load_r, rd_reset, ftm_r, rd_async_r, flag_async_r;
    logic rstb_d, rwd_d, rdsel_q, out_valid, fetch_pend, rsel;
    ptr_type wr_gray_r, wr_ptr_r, rd_ptr, rd_gray, mark_ptr, rd_count;
    offset_type empty_offset_r, full_offset_r;
    word_type mem_rdata;
    logic rd_request, data_read, fetch, empty_r, rwd_fall;
    logic rd_empty_n, rd_ae_n, rd_af_n;

    // pins sampled into the write domain
    sync_bits #(.WIDTH(11)) write_pins (
        .clock(clock),
        .async_in({master_reset_n, partial_reset_n, mode_or_serial_input, write_strobe,
                   serial_clock, serial_load_enable_n, default_offset_select_1,
                   default_offset_select_0, read_port_async_select,
                   write_port_async_select, almost_flag_timing_select}),
        .sync_out(wpin)
    );
    assign {mres_s, pres_s, ser_s, wstb_s, sclk_s, sle_s, dsel1_s, dsel0_s, rmode_s, wmode_s, afm_s} = wpin;
    assign wr_reset = rst | ~mres_s;

    // default offset table, indexed by load pin and the two selects
    function automatic offset_type default_offset(logic [2:0] sel);
        case (sel)
            3'h0: return `OFFSET_DEFAULT_0;
            3'h1: return `OFFSET_DEFAULT_1;
            3'h2: return `OFFSET_DEFAULT_2;
            3'h3: return `OFFSET_DEFAULT_3;
            3'h4: return `OFFSET_DEFAULT_4;
            3'h5: return `OFFSET_DEFAULT_5;
            3'h6: return `OFFSET_DEFAULT_6;
            default: return `OFFSET_DEFAULT_7;
        endcase
    endfunction

    // configuration captured for as long as master reset is held
    always_ff @(posedge clock)
    begin
        if (wr_reset)
        begin
            fall_through_mode <= ser_s; // see RULE_18
            rd_async <= ~rmode_s; // see RULE_23
            wr_async <= ~wmode_s; // see RULE_24
            parallel_load <= offset_load_n; // see RULE_25
            flag_async <= ~afm_s; // see RULE_21
        end
    end

    // offset registers: defaults, serial shift, parallel load; partial reset keeps them
    always_ff @(posedge clock)
    begin
        sclk_d <= sclk_s;
        if (wr_reset)
        begin
            empty_offset <= default_offset({offset_load_n, dsel1_s, dsel0_s}); // see RULE_14
            full_offset <= default_offset({offset_load_n, dsel1_s, dsel0_s});
            par_sel <= 1'b0;
        end
        else if (!parallel_load && sclk_s && !sclk_d && !sle_s && !offset_load_n)
        begin
            {full_offset, empty_offset} <= {ser_s, full_offset, empty_offset[`OFFSET_BITS-1:1]}; // see RULE_15
        end
        else if (parallel_load && !write_enable_n && !offset_load_n)
        begin
            par_sel <= ~par_sel; // empty offset first, then full
            if (par_sel)
            begin
                full_offset <= input_data_bus[`OFFSET_BITS-1:0]; // see RULE_16
            end
            else
            begin
                empty_offset <= input_data_bus[`OFFSET_BITS-1:0]; // see RULE_16
            end
        end
    end

    // write request: clocked enable or strobe edge, gated by chip select and full
    assign wr_request = wr_async ? (wstb_s & ~wstb_d) : ~write_enable_n; // see RULE_02 RULE_03
    assign full = (wr_ptr ^ rd_ptr_w) == `FULL_XOR;
    assign wr_fire = wr_request & offset_load_n & ~write_chip_select_n & ~full & pres_s; // see RULE_04 RULE_26

    // write pointer; both resets return it to the first location
    always_ff @(posedge clock)
    begin
        wstb_d <= wstb_s;
        reset_level <= wr_reset | ~pres_s;
        if (wr_reset || !pres_s)
        begin
            wr_ptr <= '0; // see RULE_18 RULE_19
            wr_gray <= '0;
        end
        else if (wr_fire)
        begin
            wr_ptr <= wr_ptr + `PTR_ONE;
            wr_gray <= to_gray(wr_ptr + `PTR_ONE); // see RULE_27
        end
    end

    // read pointer seen from the write side is always a stale, safe value
    sync_bits #(.WIDTH(`PTR_BITS)) rd_ptr_cross (
        .clock(clock),
        .async_in(rd_gray),
        .sync_out(rd_gray_w)
    );
    assign rd_ptr_w = from_gray(rd_gray_w); // see RULE_09
    assign wr_count = wr_ptr - rd_ptr_w;

    // write-side flags
    always_ff @(posedge clock)
    begin
        if (reset_level)
        begin
            wr_full_n <= 1'b1;
            wr_ae_n <= 1'b0;
            wr_af_n <= 1'b1;
        end
        else
        begin
            wr_full_n <= ~full; // see RULE_12
            wr_ae_n <= wr_count > {1'b0, empty_offset}; // see RULE_20
            wr_af_n <= wr_count < (`DEPTH - {1'b0, full_offset}); // see RULE_21
        end
    end

    // the array itself
    fifo_storage storage (
        .write_clock(clock),
        .write_en(wr_fire),
        .write_addr(wr_ptr[`ADDR_BITS-1:0]),
        .write_data(input_data_bus),
        .read_clock(read_clock),
        .read_addr(rd_ptr[`ADDR_BITS-1:0]),
        .read_data(mem_rdata)
    ); // see RULE_01

    // ---- read domain
    // quasi-static settings and pins into the read domain
    sync_bits #(.WIDTH(7)) read_pins (
        .clock(read_clock),
        .async_in({read_strobe, retransmit_n, offset_load_n, reset_level,
                   fall_through_mode & ~rd_async, rd_async, flag_async}),
        .sync_out(rpin)
    ); // see RULE_07
    assign {rstb_s, rwd_s, load_r, rd_reset, ftm_r, rd_async_r, flag_async_r} = rpin;

    // offsets change only while no reads use them, so a bitwise crossing is enough
    sync_bits #(.WIDTH(2*`OFFSET_BITS)) offset_cross (
        .clock(read_clock),
        .async_in({full_offset, empty_offset}),
        .sync_out({full_offset_r, empty_offset_r})
    );
    sync_bits #(.WIDTH(`PTR_BITS)) wr_ptr_cross (
        .clock(read_clock),
        .async_in(wr_gray),
        .sync_out(wr_gray_r)
    );
    assign wr_ptr_r = from_gray(wr_gray_r); // see RULE_27
    assign rd_count = wr_ptr_r - rd_ptr;
    assign empty_r = rd_count == '0;

    // read request and fetch decision
    assign rd_request = rd_async_r ? (rstb_s & ~rstb_d) : ~read_enable_n; // see RULE_05 RULE_06
    assign data_read = rd_request & load_r;
    assign rwd_fall = rwd_d & ~rwd_s;
    always_comb
    begin
        if (ftm_r)
        begin
            fetch = ~empty_r & ~fetch_pend & (~out_valid | data_read); // see RULE_11
        end
        else
        begin
            fetch = ~empty_r & data_read; // see RULE_10 RULE_26
        end
    end

    // read pointer, mark and retransmit
    always_ff @(posedge read_clock)
    begin
        rstb_d <= rstb_s;
        rwd_d <= rwd_s;
        if (rd_reset)
        begin
            rd_ptr <= '0; // see RULE_18 RULE_19
            rd_gray <= '0;
            mark_ptr <= '0;
        end
        else if (rwd_fall)
        begin
            rd_ptr <= mark_ptr; // see RULE_22
            rd_gray <= to_gray(mark_ptr);
        end
        else if (fetch)
        begin
            rd_ptr <= rd_ptr + `PTR_ONE;
            rd_gray <= to_gray(rd_ptr + `PTR_ONE);
            if (replay_mark)
            begin
                mark_ptr <= rd_ptr; // see RULE_22
            end
        end
    end

    // output word: memory data one edge after the fetch, or an offset readback
    always_ff @(posedge read_clock)
    begin
        if (rd_reset || rwd_fall)
        begin
            output_data_bus <= '0;
            out_valid <= 1'b0;
            fetch_pend <= 1'b0;
            rsel <= 1'b0;
        end
        else
        begin
            fetch_pend <= fetch;
            if (rd_request && !load_r)
            begin
                rsel <= ~rsel;
                output_data_bus <= {17'h00000, rsel ? full_offset_r : empty_offset_r}; // see RULE_17
            end
            else if (fetch_pend)
            begin
                output_data_bus <= mem_rdata;
            end
            if (fetch_pend)
            begin
                out_valid <= 1'b1;
            end
            else if (data_read && !fetch)
            begin
                out_valid <= 1'b0;
            end
        end
    end

    // read-side flags; chip select sampled on the read clock
    always_ff @(posedge read_clock)
    begin
        rdsel_q <= read_chip_select_n;
        if (rd_reset)
        begin
            rd_empty_n <= 1'b0;
            rd_ae_n <= 1'b0;
            rd_af_n <= 1'b1;
        end
        else
        begin
            rd_empty_n <= ftm_r ? out_valid : ~empty_r; // see RULE_12
            rd_ae_n <= rd_count > {1'b0, empty_offset_r}; // see RULE_21
            rd_af_n <= rd_count < (`DEPTH - {1'b0, full_offset_r}); // see RULE_20
        end
    end

    // output drive and the flag pairs; both copies of a pair carry the same state here
    assign output_data_enable = ~output_enable_n & ~rdsel_q; // see RULE_08
    assign empty_flag_n = {2{ftm_r ? ~rd_empty_n : rd_empty_n}}; // see RULE_13
    assign full_flag_n = {2{fall_through_mode ? ~wr_full_n : wr_full_n}}; // see RULE_13
    // asynchronous mode: either side pulls low, so almost empty falls on a read edge and almost full on a write edge
    assign almost_empty_flag_n = {2{flag_async_r ? (rd_ae_n & wr_ae_n) : rd_ae_n}}; // see RULE_20 RULE_21
    assign almost_full_flag_n = {2{flag_async ? (rd_af_n & wr_af_n) : wr_af_n}}; // see RULE_20 RULE_21

    // ---- checks, write domain
    sequence write_taken_s;
        wr_fire;
    endsequence

    write_advances_a: assert property (@(posedge clock) disable iff (reset_level) // see RULE_02
        write_taken_s |=> wr_ptr == $past(wr_ptr) + `PTR_ONE)
        else $error("write pointer did not advance after a write");
    full_blocks_write_a: assert property (@(posedge clock) disable iff (reset_level) // see RULE_26
        full |-> !wr_fire)
        else $error("write accepted while full");
    select_blocks_write_a: assert property (@(posedge clock) disable iff (reset_level) // see RULE_04
        write_chip_select_n && pres_s && !wr_reset |=> $stable(wr_ptr))
        else $error("write pointer moved with chip select high");
    reset_clears_ptr_a: assert property (@(posedge clock) // see RULE_18
        wr_reset |=> wr_ptr == '0 && wr_gray == '0)
        else $error("write pointer not cleared by reset");
    gray_one_step_a: assert property (@(posedge clock) disable iff (reset_level) // see RULE_27
        $onehot0(wr_gray ^ $past(wr_gray)))
        else $error("write gray pointer changed by more than one bit");
    serial_shift_a: assert property (@(posedge clock) disable iff (wr_reset) // see RULE_15
        !parallel_load && sclk_s && !sclk_d && !sle_s && !offset_load_n
        |=> full_offset[`OFFSET_BITS-1] == $past(ser_s) && empty_offset == $past({full_offset[0], empty_offset[18:1]}))
        else $error("serial offset shift wrong");

    // ---- checks, read domain
    sequence std_read_s;
        fetch && !ftm_r ##1 fetch_pend;
    endsequence

    read_advances_a: assert property (@(posedge read_clock) disable iff (rd_reset) // see RULE_05
        fetch && !rwd_fall |=> rd_ptr == $past(rd_ptr) + `PTR_ONE)
        else $error("read pointer did not advance after a read");
    std_read_data_a: assert property (@(posedge read_clock) disable iff (rd_reset || rwd_fall) // see RULE_10
        std_read_s ##0 load_r |=> output_data_bus == $past(mem_rdata) && out_valid)
        else $error("read data not presented one edge after fetch");
    empty_blocks_read_a: assert property (@(posedge read_clock) disable iff (rd_reset) // see RULE_26
        empty_r |-> !fetch)
        else $error("read performed while empty");
    three_state_a: assert property (@(posedge read_clock) // see RULE_08
        output_enable_n || $past(read_chip_select_n) |-> !output_data_enable)
        else $error("output driven while disabled");
    retransmit_load_a: assert property (@(posedge read_clock) disable iff (rd_reset) // see RULE_22
        rwd_fall |=> rd_ptr == $past(mark_ptr) && !out_valid)
        else $error("retransmit did not reload the marked location");
endmodule

// [dual_clock_deep_fifo_x36_test.sv]
// self-checking bench of the deep dual-clock fifo
// assumes the design files and fifo_reader_model are compiled first
module dual_clock_deep_fifo_x36_test
    import fifo_x36_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rst, read_clock, write_enable_n, write_strobe, write_chip_select_n;
    logic read_enable_n, read_strobe, read_chip_select_n, output_enable_n, output_data_enable;
    logic master_reset_n, partial_reset_n, mode_or_serial_input, default_offset_select_0;
    logic default_offset_select_1, offset_load_n, serial_clock, serial_load_enable_n;
    logic almost_flag_timing_select, read_port_async_select, write_port_async_select;
    logic replay_mark, retransmit_n;
    logic [1:0] empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
    word_type input_data_bus, output_data_bus, w;
    int errors, compares;

    deep_fifo_x36 uut (.clock(clock), .rst(rst), .read_clock(read_clock),
        .input_data_bus(input_data_bus), .write_enable_n(write_enable_n), .write_strobe(write_strobe),
        .write_chip_select_n(write_chip_select_n), .read_enable_n(read_enable_n),
        .read_strobe(read_strobe), .read_chip_select_n(read_chip_select_n),
        .output_enable_n(output_enable_n), .output_data_bus(output_data_bus),
        .output_data_enable(output_data_enable), .master_reset_n(master_reset_n),
        .partial_reset_n(partial_reset_n), .mode_or_serial_input(mode_or_serial_input),
        .default_offset_select_0(default_offset_select_0), .default_offset_select_1(default_offset_select_1),
        .offset_load_n(offset_load_n), .serial_clock(serial_clock), .serial_load_enable_n(serial_load_enable_n),
        .almost_flag_timing_select(almost_flag_timing_select),
        .read_port_async_select(read_port_async_select), .write_port_async_select(write_port_async_select),
        .replay_mark(replay_mark), .retransmit_n(retransmit_n), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
        .almost_full_flag_n(almost_full_flag_n));

    fifo_reader_model rd (.read_clock(read_clock), .output_data_bus(output_data_bus),
        .read_enable_n(read_enable_n), .read_strobe(read_strobe), .replay_mark(replay_mark),
        .retransmit_n(retransmit_n));

    // 200 mhz write clock, 30 ns read clock with an odd phase
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        read_clock = 1'b0;
        #7.3;
        forever #15 read_clock = ~read_clock;
    end

    task automatic check(input word_type seen, input word_type exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // back-to-back words on the write clock, base first
    task automatic write_words(input word_type base, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(negedge clock);
            write_enable_n = 1'b0;
            input_data_bus = base + word_type'(i);
        end
        @(negedge clock);
        write_enable_n = 1'b1;
    endtask

    // bounded wait for the empty flag pair; pointer crossing takes a few edges
    task automatic wait_flag(input logic [1:0] want);
        int n;
        n = 0;
        while (empty_flag_n !== want && n < 60)
        begin
            @(negedge read_clock);
            n++;
        end
        if (n >= 60)
        begin
            errors++;
            $display("unexpected at %0t: flag wait timed out", $time);
            tally_and_finish();
        end
        else
            check({34'h0, empty_flag_n}, {34'h0, want}, "empty flag");
    endtask

    // pins held at their master reset choices: clocked ports, standard, parallel, sync flags
    initial
    begin
        {write_enable_n, write_chip_select_n, read_chip_select_n, output_enable_n} = 4'h8;
        {write_strobe, serial_clock, serial_load_enable_n, mode_or_serial_input} = 4'h2;
        {master_reset_n, partial_reset_n, default_offset_select_0, default_offset_select_1} = 4'hc;
        {offset_load_n, almost_flag_timing_select, read_port_async_select, write_port_async_select} = 4'hf;
        input_data_bus = 36'h0;
        errors = 0;
        compares = 0;
        rst = 1'b1;
        // held past 3 cycles: the read side needs 3 of its own edges
        repeat (5) @(negedge read_clock);
        @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge read_clock);
        check({34'h0, empty_flag_n}, 36'h0, "empty after reset");
        check({34'h0, full_flag_n}, 36'h3, "full after reset");
        check({34'h0, almost_empty_flag_n}, 36'h0, "almost empty after reset");
        check({34'h0, almost_full_flag_n}, 36'h3, "almost full after reset");
        // writes with chip select high leave the fifo empty
        write_chip_select_n = 1'b1;
        write_words(36'h1, 2);
        write_chip_select_n = 1'b0;
        repeat (10) @(negedge read_clock);
        check({34'h0, empty_flag_n}, 36'h0, "deselected write");
        rd.pull(2, 1'b0, w);
        check(w, 36'h0, "read while empty");
        // four words, mark the first, rewind, then strict order
        write_words(36'h9a5a50000, 4);
        wait_flag(2'b11);
        check(output_data_bus, 36'h0, "no word before a read");
        rd.pull(2, 1'b1, w);
        check(w, 36'h9a5a50000, "first word");
        rd.pull(2, 1'b0, w);
        check(w, 36'h9a5a50001, "second word");
        rd.rewind();
        for (int i = 0; i < 4; i++)
        begin
            rd.pull(2, 1'b0, w);
            check(w, 36'h9a5a50000 + word_type'(i), "word after rewind");
        end
        wait_flag(2'b00);
        // parallel offsets 2 and 3, then read them back
        offset_load_n = 1'b0;
        write_words(36'h2, 2);
        // the load pin and the offsets need two read edges to cross
        repeat (3) @(negedge read_clock);
        rd.pull(1, 1'b0, w);
        check(w, 36'h2, "empty offset");
        rd.pull(1, 1'b0, w);
        check(w, 36'h3, "full offset");
        offset_load_n = 1'b1;
        // four words sit above the empty offset of 2
        write_words(36'h40, 4);
        wait_flag(2'b11);
        repeat (10) @(negedge read_clock);
        check({34'h0, almost_empty_flag_n}, 36'h3, "almost empty released");
        // partial reset empties the fifo but keeps the offsets
        @(negedge clock);
        partial_reset_n = 1'b0;
        repeat (6) @(negedge read_clock);
        partial_reset_n = 1'b1;
        repeat (10) @(negedge read_clock);
        check({34'h0, empty_flag_n}, 36'h0, "empty after partial");
        check({34'h0, almost_empty_flag_n}, 36'h0, "almost empty after partial");
        offset_load_n = 1'b0;
        repeat (3) @(negedge read_clock);
        rd.pull(1, 1'b0, w);
        check(w, 36'h2, "kept empty offset");
        offset_load_n = 1'b1;
        // bus float from output enable and from sampled chip select
        @(negedge clock);
        output_enable_n = 1'b1;
        #1 check({35'h0, output_data_enable}, 36'h0, "enable off");
        @(negedge clock);
        output_enable_n = 1'b0;
        #1 check({35'h0, output_data_enable}, 36'h1, "enable on");
        @(negedge clock);
        read_chip_select_n = 1'b1;
        repeat (3) @(negedge read_clock);
        check({35'h0, output_data_enable}, 36'h0, "chip select off");
        tally_and_finish();
    end
endmodule

// [fifo_reader_model.sv]
// consumer model on the read port of the deep fifo
// assumes the bench makes read_clock; words are pulled through the pull task
module fifo_reader_model
    import fifo_x36_pkg::*;
(
    input wire logic read_clock,
    input wire word_type output_data_bus,
    output logic read_enable_n,
    output logic read_strobe,
    output logic replay_mark,
    output logic retransmit_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels; strobe stays low since the port runs clocked
    initial
    begin
        read_enable_n = 1'b1;
        read_strobe = 1'b0;
        replay_mark = 1'b0;
        retransmit_n = 1'b1;
    end

    // one read edge, optional mark, result taken lat edges later
    task automatic pull(input int lat, input logic mark, output word_type w);
        @(negedge read_clock);
        read_enable_n = 1'b0;
        replay_mark = mark;
        @(posedge read_clock);
        @(negedge read_clock);
        read_enable_n = 1'b1;
        replay_mark = 1'b0;
        repeat (lat) @(posedge read_clock);
        @(negedge read_clock);
        w = output_data_bus;
    endtask

    // low pulse long enough to cross the two-flop sync
    task automatic rewind;
        @(negedge read_clock);
        retransmit_n = 1'b0;
        repeat (3) @(negedge read_clock);
        retransmit_n = 1'b1;
        repeat (4) @(negedge read_clock);
    endtask
endmodule

// [fifo_storage.sv]
// storage array of the fifo: one write port, one registered read port
// assumes the two ports sit on independent clocks and never address one word at once
module fifo_storage
    import fifo_x36_pkg::*;
(
    input wire logic write_clock,
    input wire logic write_en,
    input wire logic [`ADDR_BITS-1:0] write_addr,
    input wire logic [`DATA_BITS-1:0] write_data,
    input wire logic read_clock,
    input wire logic [`ADDR_BITS-1:0] read_addr,
    output word_type read_data
);
    word_type mem [0:`DEPTH-1];

    // write side
    always_ff @(posedge write_clock)
    begin
        if (write_en)
        begin
            mem[write_addr] <= write_data;
        end
    end

    // read data always leaves through a register
    always_ff @(posedge read_clock)
    begin
        read_data <= mem[read_addr];
    end
endmodule

// [fifo_x36_pkg.sv]
// types and gray-code helpers shared by the fifo modules
// assumes fifo_x36_regs.svh is on the include path
package fifo_x36_pkg;
`include "fifo_x36_regs.svh"
    typedef logic [`PTR_BITS-1:0] ptr_type;
    typedef logic [`DATA_BITS-1:0] word_type;
    typedef logic [`OFFSET_BITS-1:0] offset_type;

    // binary to gray, one bit flips per step
    function automatic ptr_type to_gray(ptr_type b);
        return b ^ (b >> 1);
    endfunction

    // gray back to binary
    function automatic ptr_type from_gray(ptr_type g);
        ptr_type b;
        b[`PTR_BITS-1] = g[`PTR_BITS-1];
        for (int i = `PTR_BITS - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction
endpackage

// [fifo_x36_regs.svh]
// constants of the deep dual-clock fifo: sizes and default offsets
// assumes inclusion from the package and from each design module
`ifndef FIFO_X36_REGS_SVH
`define FIFO_X36_REGS_SVH
`define DATA_BITS 36
`define ADDR_BITS 19
`define PTR_BITS 20
`define OFFSET_BITS 19
`define DEPTH 20'h80000
`define PTR_ONE 20'h00001
`define FULL_XOR 20'h80000
`define OFFSET_DEFAULT_0 19'h00007
`define OFFSET_DEFAULT_1 19'h0000f
`define OFFSET_DEFAULT_2 19'h0001f
`define OFFSET_DEFAULT_3 19'h0003f
`define OFFSET_DEFAULT_4 19'h0007f
`define OFFSET_DEFAULT_5 19'h000ff
`define OFFSET_DEFAULT_6 19'h001ff
`define OFFSET_DEFAULT_7 19'h003ff
`endif

// [sync_bits.sv]
// two-flop level synchroniser, one chain per bit
// assumes each bit is a level or a gray-coded value that steps one bit at a time
module sync_bits #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    // first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : chain
            always_ff @(posedge clock)
            begin
                stage[i] <= async_in[i];
                sync_out[i] <= stage[i];
            end
        end
    endgenerate
endmodule
